//--- hw/oss_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
`include "oss_consts.svh"
module oss_buf2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire oss_pkg::oss_word_t inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output oss_pkg::oss_word_t outData
);
  import oss_pkg::*;
  oss_word_t mem0;
  oss_word_t mem1;
  logic [1:0] count;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  // Entry 0 is the head; read data come out of a register.
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 2'h0;
      mem0 <= `OSS_ALL_OFF;
      mem1 <= `OSS_ALL_OFF;
    end else begin
      count <= count + {1'b0, doPush} - {1'b0, doPop};
      if (doPop) begin
        mem0 <= (count == 2'h2) ? mem1 : inData;
      end else if (doPush && count == 2'h0) begin
        mem0 <= inData;
      end
      if (doPush && ((count == 2'h1 && !doPop) || (count == 2'h2))) begin
        mem1 <= inData;
      end
    end
  end
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem0;
  bufNoOverflow_a: assert property (@(posedge clk) disable iff (rst) count != 2'h3)
    else $error("Buffer count out of range.");
endmodule

//--- hw/oss_consts.svh
// Constants of the octal switch serial control block.
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH
`define OSS_WORD_BITS 8
`define OSS_MSB 7
`define OSS_ALL_OFF 8'hFF
`define OSS_CNT_ZERO 3'h0
`define OSS_CNT_LAST 3'h7
`endif

//--- hw/oss_pkg.sv
// Types of the octal switch serial control block.
package oss_pkg;
  typedef logic [7:0] oss_word_t;
  typedef enum logic [1:0] {OSS_IDLE, OSS_SHIFT, OSS_LATCH} oss_state_t;
endpackage

//--- hw/oss_serial_ctrl.sv
// Serial control logic of an eight output low side switch.
`timescale 1ns/100ps
`include "oss_consts.svh"
// Notes on behaviour
// - One eight-bit command word controls eight outputs, one bit each.
// - A low command bit turns its output on, high turns it off.
// - While commands shift in, drain status of each output shifts out.
// - Each serial clock moves one bit in each direction simultaneously.
// - Chip select rising loads the shifted word into all outputs together.
// - Chip select falling loads present drain status into the shift register; the code loads it on the first link clock rising edge instead.
// - Words shift most significant bit first, output 7 down to 0.
// - Reset low sets the shift register to all ones and forces all outputs off.
module oss_serial_ctrl (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link from the master
  input wire logic serClk,
  input wire logic chipSelN,
  input wire logic serIn,
  output logic serOut,
  output logic serOutEn,
  // Device pins
  input wire logic resetN,
  input wire oss_pkg::oss_word_t drainStatus,
  output oss_pkg::oss_word_t outOn,
  output oss_pkg::oss_word_t outCmd,
  output logic frameDone
);
  import oss_pkg::*;

  // Link domain: synchronise the asynchronous reset pin and chip select.
  logic rstL1;
  logic rstL2;
  logic csL1;
  logic csL2;
  logic csL3;
  // Drain status is synchronised on the system clock and frozen while selected.
  oss_word_t drS1;
  oss_word_t drS2;
  oss_word_t statusSnap;
  always_ff @(posedge serClk) begin
    rstL1 <= resetN;
    rstL2 <= rstL1;
    csL1 <= chipSelN;
    csL2 <= csL1;
  end
  wire linkRst = !rstL2;

  // The shift register is clocked by the link clock; the master keeps SCLK low at
  // chip select edges, so frame start is seen on the first rising edge in the frame.
  oss_word_t shiftReg;
  logic inFrame;
  logic soBit;
  wire frameStart = !chipSelN && !inFrame;
  // Chip select high clears the frame flag at once, since no link clock runs between frames.
  always_ff @(posedge serClk or posedge chipSelN) begin
    if (chipSelN) begin
      inFrame <= 1'b0;
    end else if (linkRst) begin
      inFrame <= 1'b0;
    end else begin
      inFrame <= 1'b1;
    end
  end
  always_ff @(posedge serClk) begin
    if (linkRst) begin
      shiftReg <= `OSS_ALL_OFF;
    end else if (chipSelN) begin
      shiftReg <= shiftReg;
    end else if (frameStart) begin
      // Status loaded at frame start, then the first bit moves in.
      shiftReg <= {statusSnap[`OSS_MSB-1:0], serIn};
    end else begin
      shiftReg <= {shiftReg[`OSS_MSB-1:0], serIn};
    end
  end
  // Output bit changes on the rising edge and is read by the master on the fall.
  always_ff @(posedge serClk) begin
    if (linkRst) begin
      soBit <= 1'b1;
    end else if (frameStart) begin
      soBit <= statusSnap[`OSS_MSB];
    end else begin
      soBit <= shiftReg[`OSS_MSB];
    end
  end
  assign serOut = soBit;
  assign serOutEn = chipSelN; // Low while driving.

  // System domain: the word is stable in the shift register once chip select
  // has risen, and the link clock has stopped, so it may be sampled after sync.
  logic csS1;
  logic csS2;
  logic csS3;
  logic rstS1;
  logic rstS2;
  always_ff @(posedge clk) begin
    if (rst) begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csS3 <= 1'b1;
      rstS1 <= 1'b0;
      rstS2 <= 1'b0;
      drS1 <= `OSS_ALL_OFF;
      drS2 <= `OSS_ALL_OFF;
      statusSnap <= `OSS_ALL_OFF;
    end else begin
      csS1 <= chipSelN;
      csS2 <= csS1;
      csS3 <= csS2;
      rstS1 <= resetN;
      rstS2 <= rstS1;
      drS1 <= drainStatus;
      drS2 <= drS1;
      // Frozen before the first link edge, so the link side reads a steady word.
      if (csS3) begin
        statusSnap <= drS2;
      end
    end
  end
  wire csRise = csS2 && !csS3;
  wire devRst = rst || !rstS2;

  // Latched word passes through the two-entry buffer so no update is lost.
  logic bufReady;
  logic bufValid;
  oss_word_t bufData;
  oss_buf2 cmdBuf (
    .clk(clk),
    .rst(devRst),
    .inValid(csRise),
    .inReady(bufReady),
    .inData(shiftReg),
    .outValid(bufValid),
    .outReady(1'b1),
    .outData(bufData)
  );

  always_ff @(posedge clk) begin
    if (devRst) begin
      outCmd <= `OSS_ALL_OFF;
      outOn <= ~`OSS_ALL_OFF;
      frameDone <= 1'b0;
    end else begin
      frameDone <= bufValid;
      if (bufValid) begin
        outCmd <= bufData;
        outOn <= ~bufData;
      end
    end
  end

  logic unusedCs;
  assign unusedCs = csL2 ^ csL3 ^ bufReady;
  always_ff @(posedge serClk) begin
    csL3 <= csL2;
  end

  outsPolarity_a: assert property (@(posedge clk) disable iff (rst) outOn == ~outCmd)
    else $error("Output polarity mismatch.");
  resetOff_a: assert property (@(posedge clk) disable iff (rst) !rstS2 |=> outOn == 8'h00)
    else $error("Outputs not off under reset.");
  latchOnRise_a: assert property (@(posedge clk) disable iff (devRst)
      csRise |-> ##[1:4] frameDone)
    else $error("Word not latched after chip select rise.");
  onlyOnRise_a: assert property (@(posedge clk) disable iff (devRst)
      $changed(outCmd) |-> $past(bufValid))
    else $error("Outputs changed without a frame end.");
  shiftIn_a: assert property (@(posedge serClk) disable iff (linkRst)
      (!chipSelN && inFrame) |-> shiftReg[0] == $past(serIn))
    else $error("Serial input bit not shifted in.");
  shiftOut_a: assert property (@(posedge serClk) disable iff (linkRst)
      (!chipSelN && inFrame && $past(inFrame)) |-> soBit == $past(shiftReg[`OSS_MSB]))
    else $error("Serial output bit not from shift register.");
  statusLoad_a: assert property (@(posedge serClk) disable iff (linkRst)
      (!chipSelN && inFrame && !$past(inFrame)) |-> soBit == $past(statusSnap[`OSS_MSB]))
    else $error("Drain status not loaded at frame start.");
  soEnable_a: assert property (@(posedge serClk) serOutEn == chipSelN)
    else $error("Serial output enable wrong.");
  frameCov_c: cover property (@(posedge clk) csRise);
  allOnCov_c: cover property (@(posedge clk) outOn == 8'hFF);
  resetCov_c: cover property (@(posedge clk) !rstS2);
endmodule

//--- testbench/oss_serial_ctrl_tb.sv
// Self-checking bench of the octal switch serial control.
`timescale 1ns/100ps
module oss_serial_ctrl_tb;
  import oss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resetN = 1'b0;
  oss_word_t drainStatus = 8'h00;
  logic serClk, chipSelN, serIn, serOut, serOutEn, frameDone;
  oss_word_t outOn, outCmd;
  logic [15:0] rx;
  int fails = 0;
  int total_checks = 0;
  // Each row holds the drain levels and the command word.
  oss_word_t rows [4][2] = '{'{8'hA5, 8'h00}, '{8'h0F, 8'hFF}, '{8'h3C, 8'h5A}, '{8'hFF, 8'h81}};
  initial begin
    forever #5 clk = ~clk;
  end
  oss_serial_ctrl oss_serial_ctrl_inst (.clk(clk), .rst(rst), .serClk(serClk),
    .chipSelN(chipSelN), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn),
    .resetN(resetN), .drainStatus(drainStatus), .outOn(outOn), .outCmd(outCmd),
    .frameDone(frameDone));
  oss_spi_master oss_spi_master_inst (.serClk(serClk), .chipSelN(chipSelN),
    .serIn(serIn), .serOut(serOut));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A missing update pulse ends the run rather than hanging it.
  task automatic waitDone();
    int k;
    for (k = 0; k < 20 && frameDone !== 1'b1; k++) @(negedge clk);
    if (k == 20) begin
      fails++;
      give_verdict();
    end
    repeat (8) @(negedge clk);
  endtask
  // Link reset needs clock edges, so the master clocks with select high meanwhile.
  task automatic pinReset();
    fork
      oss_spi_master_inst.xfer(16'h0000, 3, 1'b1, rx);
      repeat (20) @(negedge clk);
    join
    rst = 1'b0;
    resetN = 1'b1;
    // The link side leaves reset only on link clock edges after release.
    oss_spi_master_inst.xfer(16'h0000, 3, 1'b1, rx);
    repeat (4) @(negedge clk);
    chk(outCmd, 8'hFF);
    chk(outOn, 8'h00);
    chk(serOutEn, 1'b1);
  endtask
  initial begin
    pinReset();
    foreach (rows[r]) begin
      drainStatus = rows[r][0];
      oss_spi_master_inst.xfer({8'h00, rows[r][1]}, 8, 1'b0, rx);
      waitDone();
      chk(rx, {8'h00, rows[r][0]});
      chk(outCmd, rows[r][1]);
      chk(outOn, oss_word_t'(~rows[r][1]));
    end
    drainStatus = 8'hC3;
    oss_spi_master_inst.xfer(16'h6A95, 16, 1'b0, rx);
    waitDone();
    chk(rx, 16'hC36A);
    chk(outCmd, 8'h95);
    oss_spi_master_inst.xfer(16'h0000, 8, 1'b1, rx);
    repeat (10) @(negedge clk);
    chk(outCmd, 8'h95);
    resetN = 1'b0;
    pinReset();
    give_verdict();
  end
endmodule

//--- testbench/oss_spi_master.sv
// Serial master model for the octal switch link.
`timescale 1ns/100ps
module oss_spi_master (
  // Link to the device
  output logic serClk,
  output logic chipSelN,
  output logic serIn,
  input wire logic serOut
);
  initial begin
    serClk = 1'b0;
    chipSelN = 1'b1;
    serIn = 1'b0;
  end
  // The clock runs only inside a burst, so a select change never meets a high clock.
  task automatic xfer(input logic [15:0] tx, input int n, input logic sel,
                      output logic [15:0] rx);
    rx = 16'h0000;
    chipSelN = sel;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      serIn = tx[i];
      #16 serClk = 1'b1;
      #16 serClk = 1'b0;
      rx[i] = serOut;
    end
    #40 chipSelN = 1'b1;
    serIn = ~serIn;
  endtask
endmodule
